/* File: tb/sifx_core_properties.sv */
// Port checker for sifx_core.
// Bound to the core; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sifx_core_chk
   import sifx_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic o_pready,
   input wire logic o_sck,
   input wire logic o_sck_oe_n,
   input wire logic o_sdo,
   input wire logic o_sdo_oe_n,
   input wire logic o_sda,
   input wire logic o_spi_pins_claimed,
   input wire logic o_i2c_pins_claimed,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   logic run;
   logic [4:0] n_tog;
   wire logic wr_dat = i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADDR_DATA;
   // Accepted write that starts a master byte
   wire logic start = wr_dat && !run && !o_sck_oe_n;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || $rose(o_irq))
         run <= 1'b0;
      else if (start)
         run <= 1'b1;
      if (start)
         n_tog <= 5'h00;
      else if (run && $changed(o_sck))
         n_tog <= n_tog + 5'h01;
   end
   sequence s_start;
      start;
   endsequence
   sequence s_done;
      $rose(o_irq) && run;
   endsequence
   property p_start;
      s_start |-> ##[1:100] $changed(o_sck);
   endproperty
   a_start: assert property (p_start) else $error("no clock after data write");
   property p_eight;
      s_done |-> ##[1:2] n_tog == 5'h10;
   endproperty
   a_eight: assert property (p_eight) else $error("wrong clock edge count");
   property p_quiet;
      (!o_sck_oe_n && !run) [*3] |-> $stable(o_sck);
   endproperty
   a_quiet: assert property (p_quiet) else $error("clock moved while idle");
   property p_idle_sdo;
      $rose(o_irq) && !o_sck_oe_n |=> o_sdo;
   endproperty
   a_idle_sdo: assert property (p_idle_sdo) else $error("serial out not high after byte");
   property p_hold;
      o_irq && !$past(i_psel && i_pwrite) |=> o_irq;
   endproperty
   a_hold: assert property (p_hold) else $error("complete flag dropped by itself");
   property p_release;
      !o_spi_pins_claimed && !o_i2c_pins_claimed |-> o_sck_oe_n && o_sdo_oe_n;
   endproperty
   a_release: assert property (p_release) else $error("pin driven while released");
   property p_sda_low;
      o_sda == 1'b0;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data line driven high");
   property p_one_owner;
      !(o_spi_pins_claimed && o_i2c_pins_claimed);
   endproperty
   a_one_owner: assert property (p_one_owner) else $error("two owners of the pins");
endmodule
bind sifx_core sifx_core_chk chk_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_sck(o_sck),
   .o_sck_oe_n(o_sck_oe_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_sda(o_sda),
   .o_spi_pins_claimed(o_spi_pins_claimed), .o_i2c_pins_claimed(o_i2c_pins_claimed), .o_irq(o_irq));
`default_nettype wire

/* File: tb/sifx_spi_partner.sv */
// Behavioural SPI slave facing the core in master mode.
// Assumes capture on the return of SCK to its idle level.
`timescale 1ns/1ps
`default_nettype none
module sifx_spi_partner (
   input wire logic i_sck,
   input wire logic i_sel_n,
   input wire logic i_pol,
   input wire logic i_msb,
   input wire logic i_mosi,
   input wire logic [7:0] i_tx,
   output logic o_sdi,
   output logic [7:0] o_rx
);
   logic [7:0] sh;
   initial o_sdi = 1'b1;
   always @(negedge i_sel_n) begin
      sh = i_tx;
      o_sdi = i_msb ? i_tx[7] : i_tx[0];
   end
   // Released line shows the inverse of its last bit
   always @(posedge i_sel_n) o_sdi = ~o_sdi;
   always @(i_sck) begin
      if (!i_sel_n && i_sck === ~i_pol) begin
         o_rx = i_msb ? {o_rx[6:0], i_mosi} : {i_mosi, o_rx[7:1]};
         sh = i_msb ? sh << 1 : sh >> 1;
         o_sdi = i_msb ? sh[7] : sh[0];
      end
   end
endmodule
`default_nettype wire

/* File: tb/test_serial_interface_spi_i2c.sv */
// Bench for sifx_core: APB software, SPI slave partner, bench-made slave SCK.
// Assumes sifx_pkg, the partner and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_serial_interface_spi_i2c
   import sifx_pkg::*;
;
   localparam logic [7:0] RST_V [6] = '{MODE_CTL_RST, BUS_STAT_RST, DATA_RST, SPI_FMT_RST, SLV_ADDR_RST, TIMEOUT_RST};
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sub = 0, tick = 0, err;
   logic sel_n = 1, t_sck = 1, t_sdi = 1, slv = 0, pol = 0, msb = 0;
   logic [7:0] addr = 0, ptx = 0, rd, got;
   logic [31:0] wd = 0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, sck, sck_oe_n, sdo, sdo_oe_n, sda, sda_oe_n, spi_cl, i2c_cl, irq, p_sdi;
   wire logic [7:0] p_rx;
   wire logic sck_w = sck_oe_n ? t_sck : sck;
   int num_errors = 0, n_compared = 0;
   sifx_core dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(addr), .i_pwdata(wd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sck(sck_w),
      .o_sck(sck), .o_sck_oe_n(sck_oe_n), .i_sdi(slv ? t_sdi : p_sdi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
      .i_slave_select_n(sel_n), .i_sda(sda_oe_n | sda), .o_sda(sda), .o_sda_oe_n(sda_oe_n), .i_sub_clk(sub),
      .i_timer_tick(tick), .o_spi_pins_claimed(spi_cl), .o_i2c_pins_claimed(i2c_cl), .o_irq(irq));
   sifx_spi_partner part_u (.i_sck(sck_w), .i_sel_n(sel_n), .i_pol(pol), .i_msb(msb), .i_mosi(sdo),
      .i_tx(ptx), .o_sdi(p_sdi), .o_rx(p_rx));
   initial forever #10 clk = ~clk; // 50 MHz system clock
   always @(posedge clk) tick <= ($urandom_range(3) == 0) && !tick;
   always @(posedge clk) sub <= ($time / 160) % 2 == 1;
   task automatic test_done;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bad(input string m);
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
      n_compared++;
      if (g !== e)
         bad(m);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      {psel, pen, pwr, addr, wd} <= {1'b1, 1'b0, w, a, 24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
      if (pready !== 1'b1) begin
         bad("bus hang");
         test_done;
      end
      rd = prdata[7:0];
      err = pslverr;
      {psel, pen} <= 2'b00;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
      apb(1'b0, a, 8'h00);
      cmp(rd, e, m);
   endtask
   task automatic wait_irq;
      for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
      if (irq !== 1'b1) begin
         bad("no completion");
         test_done;
      end
   endtask
   // Bench acts as external master: k bits MSB first, 160 ns SCK
   task automatic slv_bits(input int k, input logic [7:0] s);
      sel_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 7; i > 7 - k; i--) begin
         t_sdi <= s[i];
         t_sck <= 1'b0;
         repeat (4) @(posedge clk);
         got[i] = sdo;
         t_sck <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
   initial begin
      logic [7:0] tx, s, fm;
      void'($urandom(32'h1be50ada));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(8'(4 * i), RST_V[i], "reset value");
      rdc(8'h18, 8'h00, "unmapped read");
      cmp({7'h0, err}, 8'h01, "unmapped error");
      apb(1'b1, ADDR_MODE_CTL, 8'hff);
      rdc(ADDR_MODE_CTL, MODE_CTL_WMASK, "mode bits");
      rdc(ADDR_SPI_FMT, 8'h00, "soft incomplete");
      cmp({5'h0, sck_oe_n, sdo_oe_n, sda_oe_n}, 8'h07, "pins released");
      for (int m = 0; m < 5; m++) begin
         fm = {2'b00, m[1], 1'b0, m[0], 3'b100};
         {pol, msb} <= {m[1], m[0]};
         apb(1'b1, ADDR_SPI_FMT, fm);
         apb(1'b1, ADDR_MODE_CTL, {m[2:0], 5'b00010});
         ptx <= 8'($urandom);
         repeat (3) @(posedge clk);
         cmp({5'h0, sck, sdo, sdo_oe_n}, {5'h0, ~m[1], 2'b10}, "idle pins");
         tx = 8'($urandom);
         sel_n <= 1'b0;
         apb(1'b1, ADDR_DATA, tx);
         apb(1'b1, ADDR_DATA, ~tx);
         wait_irq;
         rdc(ADDR_SPI_FMT, fm | 8'h03, "flags");
         rdc(ADDR_DATA, ptx, "master rx");
         cmp(p_rx, tx, "master tx");
         apb(1'b1, ADDR_SPI_FMT, fm);
         sel_n <= 1'b1;
         apb(1'b1, ADDR_MODE_CTL, 8'h00);
      end
      slv <= 1'b1;
      apb(1'b1, ADDR_SPI_FMT, 8'h0c);
      apb(1'b1, ADDR_MODE_CTL, {MODE_SPI_SLV, 5'b00010});
      tx = 8'($urandom);
      s = 8'($urandom);
      apb(1'b1, ADDR_DATA, tx);
      slv_bits(8, s);
      wait_irq;
      cmp(got, tx, "slave out");
      rdc(ADDR_DATA, s, "slave in");
      cmp({7'h0, sck_oe_n}, 8'h01, "slave sck");
      apb(1'b1, ADDR_SPI_FMT, 8'h0c);
      sel_n <= 1'b1;
      repeat (4) @(posedge clk);
      slv_bits(3, s);
      sel_n <= 1'b1;
      t_sdi <= ~t_sdi;
      wait_irq;
      rdc(ADDR_MODE_CTL, {MODE_SPI_SLV, 5'b00011}, "incomplete");
      rdc(ADDR_SPI_FMT, 8'h0d, "abort complete");
      apb(1'b1, ADDR_MODE_CTL, {MODE_I2C_SLV, 5'b00010});
      repeat (2) @(posedge clk);
      cmp({4'h0, i2c_cl, sck_oe_n, sdo_oe_n, sda_oe_n}, 8'h0f, "i2c pins");
      test_done;
   end
endmodule
`default_nettype wire

/* File: verilog/sifx_core.sv */
// Shared SPI master/slave and I2C slave serial interface with an APB register file.
// Assumes pins arrive asynchronously and are synchronised here; i_timer_tick is a
// one-cycle pulse on i_clk_sys. Open-drain and tristate pins use active-low enables.
//
// Summary of operation
// [R1] Master data write loads the shift register and starts clocking at once.
// [R2] Byte fully shifted sets transfer complete; software clears it.
// [R3] Slave shifts out and in on each received SCK pulse.
// [R4] Select enable plus select low precede a transfer.
// [R5] Select enable low: select line undriven and ignored.
// [R6] Master enabled and idle: serial input undriven, serial output high.
// [R7] Master holds SCK at the polarity idle level between transfers.
// [R8] Slave never drives SCK.
// [R9] Module disabled: all interface pins released.
// [R10] Only the master makes SCK, and only after a data write.
// [R11] In slave mode the external master supplies SCK.
// [R12] Software matches bit order to the partner before transfers.
// [R13] Received bits collect in the shift register, latched when complete.
// [R14] Master software: configure, enable, write, check collision, wait, read, clear.
// [R15] Slave software preloads data then waits for select and clock.
// [R16] Data write during a transfer is dropped and sets write collision.
// [R17] I2C SCL filtered by optional 2 or 4 system-clock debounce.
// [R18] System clock fast enough for the chosen I2C rate and debounce.
// [R19] I2C mode is slave only, transmit and receive.
// [R20] I2C lines only pulled low, otherwise released.
// [R21] I2C selection only by matching received address.
// [R22] Mode field: master clocks 000-100, SPI slave 101, I2C slave 110.
// [R23] Polarity sets SCK idle level, edge bit picks capture edge.
// [R24] Slave select lost mid-byte sets incomplete and complete; software set does not.
// [R25] Debounce field: 00 none, 01 two clocks, 1x four clocks.
// [R26] Transfer complete raises the interrupt request.
// [R27] Master shifts exactly eight bits in chosen order and rate.
`timescale 1ns/1ps
`default_nettype none
module sifx_core
   import sifx_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe_n,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe_n,
   input wire logic i_slave_select_n,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input wire logic i_sub_clk,
   input wire logic i_timer_tick,
   output logic o_spi_pins_claimed,
   output logic o_i2c_pins_claimed,
   output logic o_irq
);
   logic [PIN_COUNT-1:0] pin_meta;
   logic [PIN_COUNT-1:0] pin_sync;
   logic sck_prev;
   logic sel_prev;
   logic sub_prev;
   logic [7:0] mode_ctl;
   logic [7:0] spi_fmt;
   logic [7:0] slv_addr;
   logic [7:0] timeout_ctl;
   logic [7:0] data_rd;
   logic [7:0] shreg;
   logic [3:0] bit_cnt;
   logic [3:0] mst_trails;
   logic [4:0] div_cnt;
   logic sck_reg;
   sifx_mst_state_t mst_state;
   sifx_edges_t mst_edge;
   sifx_edges_t slv_edge;
   logic [1:0] filt;
   logic [1:0] filt_prev;
   logic [2:0] deb_cnt [2];
   sifx_i2c_state_t i2c_state;
   logic [3:0] i2c_cnt;
   logic [7:0] i2c_in;
   logic [7:0] i2c_out;
   logic sda_pull;
   logic i2c_done;
   logic addr_match;
   logic bus_busy;
   logic slv_tx;
   logic tx_nack;
   logic rd_req;
   logic wake_en;
   logic rx_nack;
   logic [31:0] rd_mux;
   logic addr_ok;

   // Pin synchronisers: second stage only is read
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_meta <= '1;
         pin_sync <= '1;
      end else begin
         pin_meta <= {i_sub_clk, i_sda, i_slave_select_n, i_sdi, i_sck};
         pin_sync <= pin_meta;
      end
   end

   // APB decode
   wire logic wr_access = i_psel & i_penable & o_pready & i_pwrite;
   wire logic wr_mode = wr_access && i_paddr == ADDR_MODE_CTL;
   wire logic wr_stat = wr_access && i_paddr == ADDR_BUS_STAT;
   wire logic wr_data = wr_access && i_paddr == ADDR_DATA;
   wire logic wr_fmt = wr_access && i_paddr == ADDR_SPI_FMT;
   wire logic wr_addr = wr_access && i_paddr == ADDR_SLV_ADDR;
   wire logic wr_tout = wr_access && i_paddr == ADDR_TIMEOUT;

   // Mode decode [R22]
   wire logic [2:0] mode = mode_ctl[MODE_HI:MODE_LO];
   wire logic enabled = mode_ctl[BIT_ENABLE];
   wire logic is_master = enabled && mode <= MODE_MST_TMR;
   wire logic is_slave = enabled && mode == MODE_SPI_SLV;
   wire logic is_i2c = enabled && mode == MODE_I2C_SLV;
   wire logic idle_lvl = ~spi_fmt[BIT_IDLE_POL];
   wire logic cap_lead = spi_fmt[BIT_CAP_EDGE];
   wire logic msb_first = spi_fmt[BIT_ORDER];
   wire logic sel_en = spi_fmt[BIT_SEL_EN];

   // Master half-period tick from the selected source
   wire logic [4:0] half_last = (mode == MODE_MST_DIV4) ? HALF_DIV4 :
                                (mode == MODE_MST_DIV16) ? HALF_DIV16 : HALF_DIV64;
   wire logic sub_edge = pin_sync[PIN_SUB] ^ sub_prev;
   wire logic half_tick = (mode == MODE_MST_SUB) ? sub_edge :
                          (mode == MODE_MST_TMR) ? i_timer_tick : (div_cnt == half_last);
   wire logic mst_run = mst_state == SIFX_MST_RUN;

   // Edge events away from and back to the idle level [R23]
   assign mst_edge.lead = mst_run & half_tick & (sck_reg == idle_lvl);
   assign mst_edge.trail = mst_run & half_tick & (sck_reg != idle_lvl);
   wire logic sel_low = ~pin_sync[PIN_SEL];
   wire logic slv_active = is_slave & (~sel_en | sel_low); // [R5] [R4]
   wire logic sck_moved = pin_sync[PIN_SCK] ^ sck_prev;
   assign slv_edge.lead = slv_active & sck_moved & (pin_sync[PIN_SCK] != idle_lvl);
   assign slv_edge.trail = slv_active & sck_moved & (pin_sync[PIN_SCK] == idle_lvl);
   wire logic lead = mst_edge.lead | slv_edge.lead;
   wire logic trail = mst_edge.trail | slv_edge.trail;
   wire logic capture = cap_lead ? lead : trail; // [R23]
   wire logic launch = cap_lead ? trail : lead;

   // Shift datapath [R3] [R27]
   wire logic rx_bit = pin_sync[PIN_SDI];
   wire logic out_bit = msb_first ? shreg[7] : shreg[0];
   wire logic [7:0] shifted = msb_first ? {shreg[6:0], rx_bit} : {rx_bit, shreg[7:1]};
   wire logic byte_done = capture && bit_cnt == LAST_BIT;
   wire logic mst_last = mst_edge.trail && mst_trails == LAST_BIT;
   wire logic busy = mst_run | (is_slave && bit_cnt != 4'h0);
   wire logic spi_mode = is_master | is_slave;
   wire logic collision = wr_data & spi_mode & busy; // [R16]
   wire logic load = wr_data & ~collision;
   wire logic sel_rise = pin_sync[PIN_SEL] & ~sel_prev;
   wire logic incomplete = is_slave & sel_en & sel_rise & (bit_cnt != 4'h0); // [R24]
   wire logic trf_set = (is_master & mst_last) | (is_slave & byte_done) | incomplete;
   wire logic [7:0] load_byte = i_pwdata[7:0];
   wire logic load_bit = msb_first ? load_byte[7] : load_byte[0];

   // I2C filtered line edges and conditions
   wire logic [2:0] deb_len = (mode_ctl[DEB_HI:DEB_LO] == DEB_NONE) ? DEB_LEN_NONE :
                              (mode_ctl[DEB_HI:DEB_LO] == DEB_TWO) ? DEB_LEN_TWO : DEB_LEN_FOUR; // [R25]
   wire logic [1:0] raw_line = {pin_sync[PIN_SDA], pin_sync[PIN_SCK]};
   wire logic scl_rise = filt[0] & ~filt_prev[0];
   wire logic scl_fall = ~filt[0] & filt_prev[0];
   wire logic scl_high = filt[0] & filt_prev[0];
   wire logic i2c_start = scl_high & filt_prev[1] & ~filt[1];
   wire logic i2c_stop = scl_high & ~filt_prev[1] & filt[1];
   wire logic i2c_live = is_i2c && i2c_state != SIFX_I2C_IDLE;
   wire logic i2c_byte_end = i2c_live & scl_fall & (i2c_cnt == LAST_BIT);
   wire logic i2c_ack_end = i2c_live & scl_fall & (i2c_cnt == ACK_SLOT);
   wire logic i2c_addr_hit = i2c_in[7:1] == slv_addr[7:1]; // [R21]
   wire logic i2c_rx_byte = i2c_byte_end & (i2c_state == SIFX_I2C_DATA) & ~slv_tx;
   wire logic i2c_send = slv_tx & ~((i2c_state == SIFX_I2C_DATA) & rx_nack);

   // Control and format registers; hardware sets win over software writes
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         mode_ctl <= MODE_CTL_RST;
         spi_fmt <= SPI_FMT_RST;
         slv_addr <= SLV_ADDR_RST;
         timeout_ctl <= TIMEOUT_RST;
      end else begin
         if (wr_mode)
            mode_ctl <= i_pwdata[7:0] & MODE_CTL_WMASK; // [R24]
         if (wr_fmt)
            spi_fmt <= i_pwdata[7:0];
         if (wr_addr)
            slv_addr <= i_pwdata[7:0];
         if (wr_tout)
            timeout_ctl <= i_pwdata[7:0];
         if (incomplete)
            mode_ctl[BIT_INCOMPLETE] <= 1'b1; // [R24]
         if (trf_set)
            spi_fmt[BIT_TRF] <= 1'b1; // [R2]
         if (collision)
            spi_fmt[BIT_WRITE_COLLISION_FLAG] <= 1'b1; // [R16]
      end
   end

   // Master clock generator
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         mst_state <= SIFX_MST_IDLE;
         div_cnt <= 5'h00;
         sck_reg <= 1'b1;
         mst_trails <= 4'h0;
         sub_prev <= 1'b1;
      end else begin
         sub_prev <= pin_sync[PIN_SUB];
         div_cnt <= (mst_run && div_cnt != half_last) ? div_cnt + 5'h01 : 5'h00;
         case (mst_state)
            SIFX_MST_IDLE: begin
               sck_reg <= idle_lvl; // [R7]
               mst_trails <= 4'h0;
               if (load && is_master)
                  mst_state <= SIFX_MST_RUN; // [R1] [R10]
            end
            SIFX_MST_RUN: begin
               if (half_tick)
                  sck_reg <= ~sck_reg;
               if (mst_edge.trail)
                  mst_trails <= mst_trails + 4'h1;
               if (mst_last || !is_master)
                  mst_state <= SIFX_MST_IDLE; // [R27]
            end
            default: mst_state <= SIFX_MST_IDLE;
         endcase
      end
   end

   // Shift register, bit counter and readable data
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         shreg <= DATA_RST;
         data_rd <= DATA_RST;
         bit_cnt <= 4'h0;
         o_sdo <= 1'b1;
         sck_prev <= 1'b1;
         sel_prev <= 1'b1;
      end else begin
         sck_prev <= pin_sync[PIN_SCK];
         sel_prev <= pin_sync[PIN_SEL];
         if (capture) begin
            shreg <= shifted; // [R13]
            bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
         end
         if (launch)
            o_sdo <= out_bit;
         if (byte_done)
            data_rd <= shifted; // [R13]
         if (is_master && !mst_run && o_sck == idle_lvl)
            o_sdo <= 1'b1; // [R6]
         if (!slv_active && !mst_run)
            bit_cnt <= 4'h0;
         if (i2c_rx_byte)
            data_rd <= i2c_in;
         if (load) begin
            shreg <= load_byte; // [R1]
            data_rd <= load_byte;
            o_sdo <= load_bit;
         end
      end
   end

   // I2C line debounce [R17]
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_deb
         always_ff @(posedge i_clk_sys) begin
            if (!i_rst_n) begin
               filt[g] <= 1'b1;
               deb_cnt[g] <= 3'h0;
            end else if (raw_line[g] == filt[g]) begin
               deb_cnt[g] <= 3'h0;
            end else if (deb_cnt[g] + 3'h1 >= deb_len) begin
               filt[g] <= raw_line[g];
               deb_cnt[g] <= 3'h0;
            end else begin
               deb_cnt[g] <= deb_cnt[g] + 3'h1;
            end
         end
      end
   endgenerate

   // I2C slave engine [R19]
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         i2c_state <= SIFX_I2C_IDLE;
         i2c_cnt <= 4'h0;
         i2c_in <= DATA_RST;
         i2c_out <= DATA_RST;
         sda_pull <= 1'b0;
         filt_prev <= 2'b11;
         {i2c_done, addr_match, bus_busy, slv_tx} <= BUS_STAT_RST[7:4];
         {tx_nack, rd_req, wake_en, rx_nack} <= BUS_STAT_RST[3:0];
      end else begin
         filt_prev <= filt;
         if (wr_stat) begin
            i2c_done <= i2c_done & i_pwdata[BIT_I2C_DONE];
            slv_tx <= i_pwdata[BIT_SLV_TX];
            tx_nack <= i_pwdata[BIT_TX_NACK];
            wake_en <= i_pwdata[BIT_WAKE];
         end
         if (!is_i2c) begin
            i2c_state <= SIFX_I2C_IDLE;
            sda_pull <= 1'b0;
            bus_busy <= 1'b0;
            addr_match <= 1'b0;
         end else if (i2c_start) begin
            i2c_state <= SIFX_I2C_ADDR;
            i2c_cnt <= 4'h0;
            sda_pull <= 1'b0;
            bus_busy <= 1'b1;
            addr_match <= 1'b0;
         end else if (i2c_stop) begin
            i2c_state <= SIFX_I2C_IDLE;
            sda_pull <= 1'b0;
            bus_busy <= 1'b0;
         end else if (i2c_live) begin
            if (scl_rise && i2c_cnt < ACK_SLOT)
               i2c_in <= {i2c_in[6:0], filt[1]};
            if (scl_rise && i2c_cnt == ACK_SLOT && slv_tx)
               rx_nack <= filt[1];
            if (i2c_byte_end) begin
               i2c_cnt <= ACK_SLOT;
               i2c_done <= 1'b1;
               if (i2c_state == SIFX_I2C_ADDR) begin
                  if (i2c_addr_hit) begin
                     addr_match <= 1'b1;
                     rd_req <= i2c_in[0];
                     slv_tx <= i2c_in[0];
                     sda_pull <= 1'b1;
                  end else begin
                     i2c_state <= SIFX_I2C_IDLE;
                     i2c_done <= i2c_done;
                  end
               end else begin
                  sda_pull <= ~slv_tx & ~tx_nack;
               end
            end else if (i2c_ack_end) begin
               i2c_cnt <= 4'h0;
               i2c_state <= i2c_send | ~slv_tx ? SIFX_I2C_DATA : SIFX_I2C_IDLE;
               i2c_out <= data_rd;
               sda_pull <= i2c_send & ~data_rd[7]; // [R20]
            end else if (scl_fall) begin
               i2c_cnt <= i2c_cnt + 4'h1;
               if (slv_tx && i2c_state == SIFX_I2C_DATA) begin
                  sda_pull <= ~i2c_out[6]; // [R20]
                  i2c_out <= {i2c_out[6:0], 1'b0};
               end
            end
         end
      end
   end

   // APB read decode
   always_comb begin
      rd_mux = 32'h0000_0000;
      addr_ok = 1'b1;
      if (i_paddr == ADDR_MODE_CTL) begin
         rd_mux[7:0] = mode_ctl;
      end else if (i_paddr == ADDR_BUS_STAT) begin
         rd_mux[7:0] = {i2c_done, addr_match, bus_busy, slv_tx, tx_nack, rd_req, wake_en, rx_nack};
      end else if (i_paddr == ADDR_DATA) begin
         rd_mux[7:0] = data_rd;
      end else if (i_paddr == ADDR_SPI_FMT) begin
         rd_mux[7:0] = spi_fmt;
      end else if (i_paddr == ADDR_SLV_ADDR) begin
         rd_mux[7:0] = slv_addr;
      end else if (i_paddr == ADDR_TIMEOUT) begin
         rd_mux[7:0] = timeout_ctl;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // APB answer and registered pin controls
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_sck <= 1'b1;
         o_sck_oe_n <= 1'b1;
         o_sdo_oe_n <= 1'b1;
         o_sda <= 1'b0;
         o_sda_oe_n <= 1'b1;
         o_spi_pins_claimed <= 1'b0;
         o_i2c_pins_claimed <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_pready <= i_psel & ~i_penable;
         o_pslverr <= i_psel & ~i_penable & ~addr_ok;
         o_prdata <= rd_mux;
         o_sck <= sck_reg;
         o_sck_oe_n <= ~is_master; // [R8] [R9] [R10]
         o_sdo_oe_n <= ~spi_mode; // [R6] [R9]
         o_sda <= 1'b0;
         o_sda_oe_n <= ~(is_i2c & sda_pull); // [R20]
         o_spi_pins_claimed <= spi_mode; // [R9]
         o_i2c_pins_claimed <= is_i2c;
         o_irq <= spi_fmt[BIT_TRF] | (is_i2c & i2c_done); // [R26]
      end
   end
endmodule
`default_nettype wire

/* File: verilog/sifx_pkg.sv */
// Register map, field positions, reset values and mode codes of the serial interface.
// Shared by the core; assumes a 32-bit APB with one register per aligned word.
package sifx_pkg;
   // Byte addresses on APB
   localparam logic [7:0] ADDR_MODE_CTL = 8'h00;
   localparam logic [7:0] ADDR_BUS_STAT = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_SPI_FMT = 8'h0c;
   localparam logic [7:0] ADDR_SLV_ADDR = 8'h10;
   localparam logic [7:0] ADDR_TIMEOUT = 8'h14;
   // Reset values
   localparam logic [7:0] MODE_CTL_RST = 8'he0;
   localparam logic [7:0] BUS_STAT_RST = 8'h81;
   localparam logic [7:0] SPI_FMT_RST = 8'h00;
   localparam logic [7:0] SLV_ADDR_RST = 8'h00;
   localparam logic [7:0] TIMEOUT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] MODE_CTL_WMASK = 8'hef;
   // mode_enable_control fields
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 5;
   localparam int DEB_HI = 3;
   localparam int DEB_LO = 2;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_INCOMPLETE = 0;
   // spi_format_control fields
   localparam int BIT_IDLE_POL = 5;
   localparam int BIT_CAP_EDGE = 4;
   localparam int BIT_ORDER = 3;
   localparam int BIT_SEL_EN = 2;
   localparam int BIT_WRITE_COLLISION_FLAG = 1;
   localparam int BIT_TRF = 0;
   // bus_status_control fields
   localparam int BIT_I2C_DONE = 7;
   localparam int BIT_ADDR_MATCH = 6;
   localparam int BIT_BUS_BUSY = 5;
   localparam int BIT_SLV_TX = 4;
   localparam int BIT_TX_NACK = 3;
   localparam int BIT_RD_REQ = 2;
   localparam int BIT_WAKE = 1;
   localparam int BIT_RX_NACK = 0;
   // Operating modes
   localparam logic [2:0] MODE_MST_DIV4 = 3'h0;
   localparam logic [2:0] MODE_MST_DIV16 = 3'h1;
   localparam logic [2:0] MODE_MST_DIV64 = 3'h2;
   localparam logic [2:0] MODE_MST_SUB = 3'h3;
   localparam logic [2:0] MODE_MST_TMR = 3'h4;
   localparam logic [2:0] MODE_SPI_SLV = 3'h5;
   localparam logic [2:0] MODE_I2C_SLV = 3'h6;
   // Last count of a half SCK period for the divided clocks
   localparam logic [4:0] HALF_DIV4 = 5'h01;
   localparam logic [4:0] HALF_DIV16 = 5'h07;
   localparam logic [4:0] HALF_DIV64 = 5'h1f;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // Debounce selection and lengths in system clocks
   localparam logic [1:0] DEB_NONE = 2'h0;
   localparam logic [1:0] DEB_TWO = 2'h1;
   localparam logic [2:0] DEB_LEN_NONE = 3'h0;
   localparam logic [2:0] DEB_LEN_TWO = 3'h2;
   localparam logic [2:0] DEB_LEN_FOUR = 3'h4;
   // Pin synchroniser lanes
   localparam int PIN_SCK = 0;
   localparam int PIN_SDI = 1;
   localparam int PIN_SEL = 2;
   localparam int PIN_SDA = 3;
   localparam int PIN_SUB = 4;
   localparam int PIN_COUNT = 5;

   typedef struct packed {
      logic lead;
      logic trail;
   } sifx_edges_t;

   typedef enum logic {SIFX_MST_IDLE, SIFX_MST_RUN} sifx_mst_state_t;
   typedef enum logic [1:0] {SIFX_I2C_IDLE, SIFX_I2C_ADDR, SIFX_I2C_DATA} sifx_i2c_state_t;
endpackage
